// ===== logic/mqrps_pkg.sv
// Constants shared by the read port select block
package mqrps_pkg;
   localparam int DATA_W = 36;
   localparam int ADDR_W = 8;
   localparam int QUEUE_W = 5;
   localparam int QUEUE_LSB = 0;
   localparam int DEV_W = 3;
   localparam int DEV_LSB = 5;
   localparam int STAT_W = 4;
   localparam int STAT_LSB = 0;
   localparam int STAT_WORDS = 16;
   localparam int FLAG_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int CFG_W = 16;
   localparam int CFG_CNT_W = 5;
   localparam logic [CFG_CNT_W-1:0] CFG_LAST = 5'h0f;
   localparam int SYNC_W = 8;
   localparam logic [FLAG_W-1:0] FLAG_IDLE = 8'hff;
   localparam logic [DEV_W-1:0] DEV_ID_RST = 3'h0;
   typedef enum logic [1:0] {
      SER_IDLE,
      SER_SHIFT,
      SER_DONE
   } mqrps_ser_t;
endpackage

// ===== logic/mqrps_top.sv
// Read port queue select, output gating, status select and serial load

// ---------------------------------------------------------------
// Word buffer
// ---------------------------------------------------------------
module mqrps_fifo #(
   parameter int W = 36,
   parameter int D = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int PW = $clog2(D);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULL = CW'(D);
   localparam logic [PW-1:0] PONE = PW'(1);
   logic [W-1:0] mem_reg [D];
   logic [W-1:0] mem_next [D];
   logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next, widx;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic wr, rd;

   assign in_ready_o = (cnt_reg != FULL);
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rptr_reg];

   always_comb begin
      wr = in_valid_i & in_ready_o;
      rd = out_valid_o & out_ready_i;
      mem_next = mem_reg;
      widx = flush_i ? '0 : wptr_reg;
      if (wr) begin
         mem_next[widx] = in_data_i;
      end
      if (flush_i) begin
         rptr_next = '0;
         wptr_next = wr ? PONE : '0;
         cnt_next = wr ? CW'(1) : '0;
      end else begin
         rptr_next = rd ? rptr_reg + PONE : rptr_reg;
         wptr_next = wr ? wptr_reg + PONE : wptr_reg;
         cnt_next = cnt_reg + CW'(wr) - CW'(rd);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < D; i++) begin
            mem_reg[i] <= '0;
         end
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule

// ---------------------------------------------------------------
// Read port top
// ---------------------------------------------------------------
module mqrps_top (
   // Read clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Pins from outside the clock domain
   input wire logic master_reset_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   input wire logic serial_in_enable_n_i,
   input wire logic serial_prog_sel_i,
   input wire logic [mqrps_pkg::DEV_W-1:0] device_id_i,
   // Read controller
   input wire logic read_chip_select_n_i,
   input wire logic read_en_n_i,
   input wire logic read_addr_enable_i,
   input wire logic flag_status_strobe_i,
   input wire logic [mqrps_pkg::ADDR_W-1:0] read_queue_addr_i,
   input wire logic fall_through_mode_i,
   input wire logic flag_polled_mode_i,
   // Read data out
   output logic [mqrps_pkg::DATA_W-1:0] read_data_o,
   output logic read_data_oe_o,
   // Queue memory
   output logic [mqrps_pkg::QUEUE_W-1:0] mem_queue_o,
   input wire logic mem_valid_i,
   input wire logic [mqrps_pkg::DATA_W-1:0] mem_data_i,
   output logic mem_ready_o,
   // Flag status
   input wire logic [mqrps_pkg::STAT_WORDS*mqrps_pkg::FLAG_W-1:0]
      ae_words_i,
   input wire logic [mqrps_pkg::STAT_WORDS*mqrps_pkg::FLAG_W-1:0]
      pr_words_i,
   output logic [mqrps_pkg::FLAG_W-1:0] almost_empty_status_bus_o,
   output logic [mqrps_pkg::FLAG_W-1:0] packet_ready_status_bus_o,
   // Serial configuration
   output logic serial_out_enable_n_o,
   output logic [mqrps_pkg::CFG_W-1:0] cfg_word_o
);
   function automatic logic dev_hit(
      input logic [mqrps_pkg::DEV_W-1:0] a,
      input logic [mqrps_pkg::DEV_W-1:0] b
   );
      dev_hit = (a == b);
   endfunction

   function automatic logic [mqrps_pkg::FLAG_W-1:0] pick_word(
      input logic [mqrps_pkg::STAT_WORDS*mqrps_pkg::FLAG_W-1:0] w,
      input logic [mqrps_pkg::STAT_W-1:0] idx
   );
      pick_word = w[idx*mqrps_pkg::FLAG_W +: mqrps_pkg::FLAG_W];
   endfunction

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [mqrps_pkg::SYNC_W-1:0] raw, s1_reg, s2_reg;
   assign raw = {master_reset_n_i, serial_clk_i, serial_data_i,
                 serial_in_enable_n_i, serial_prog_sel_i, device_id_i};
   genvar g;
   generate
      for (g = 0; g < mqrps_pkg::SYNC_W; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               s1_reg[g] <= 1'b0;
               s2_reg[g] <= 1'b0;
            end else begin
               s1_reg[g] <= raw[g];
               s2_reg[g] <= s1_reg[g];
            end
         end
      end
   endgenerate
   logic mrs_active, sclk_s, si_s, serial_in_enable_n_s, prog_s;
   logic [mqrps_pkg::DEV_W-1:0] id_s;
   assign {sclk_s, si_s, serial_in_enable_n_s, prog_s, id_s} = s2_reg[6:0];
   assign mrs_active = !s2_reg[7];

   // ------------------------------------------------------------
   // Queue select and read data
   // ------------------------------------------------------------
   logic [mqrps_pkg::QUEUE_W-1:0] queue_reg, queue_next;
   logic [mqrps_pkg::DEV_W-1:0] rdev_reg, rdev_next, id_reg, id_next;
   logic [mqrps_pkg::DATA_W-1:0] q_reg, q_next;
   logic q_valid_reg, q_valid_next, pend_reg, pend_next;
   logic sel_fire, rd_req, load, selected, ser_done;
   logic fifo_ov;
   logic [mqrps_pkg::DATA_W-1:0] fifo_od;
   logic [mqrps_pkg::ADDR_W-1:0] a;
   assign a = read_queue_addr_i;

   mqrps_fifo #(
      .W(mqrps_pkg::DATA_W),
      .D(mqrps_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .flush_i(sel_fire | mrs_active),
      .in_valid_i(mem_valid_i),
      .in_data_i(mem_data_i),
      .in_ready_o(mem_ready_o),
      .out_valid_o(fifo_ov),
      .out_data_o(fifo_od),
      .out_ready_i(load)
   );

   always_comb begin
      sel_fire = read_addr_enable_i & ser_done & !mrs_active;
      selected = dev_hit(rdev_reg, id_reg);
      rd_req = !read_en_n_i & selected & !mrs_active;
      load = fifo_ov & (rd_req | (fall_through_mode_i & selected
             & (pend_reg | !q_valid_reg)));
      queue_next = queue_reg;
      rdev_next = rdev_reg;
      if (sel_fire) begin
         queue_next = a[mqrps_pkg::QUEUE_LSB +: mqrps_pkg::QUEUE_W];
         rdev_next = a[mqrps_pkg::DEV_LSB +: mqrps_pkg::DEV_W];
      end
      mem_queue_o = sel_fire ? queue_next : queue_reg;
      id_next = mrs_active ? id_s : id_reg;
      pend_next = sel_fire;
      q_next = load ? fifo_od : q_reg;
      if (sel_fire | mrs_active) begin
         q_valid_next = 1'b0;
      end else if (load) begin
         q_valid_next = 1'b1;
      end else begin
         q_valid_next = q_valid_reg;
      end
      read_data_oe_o = !read_chip_select_n_i & !read_en_n_i
                       & selected & !mrs_active;
   end
   assign read_data_o = q_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         queue_reg <= '0;
         rdev_reg <= mqrps_pkg::DEV_ID_RST;
         id_reg <= mqrps_pkg::DEV_ID_RST;
         q_reg <= '0;
         q_valid_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         queue_reg <= queue_next;
         rdev_reg <= rdev_next;
         id_reg <= id_next;
         q_reg <= q_next;
         q_valid_reg <= q_valid_next;
         pend_reg <= pend_next;
      end
   end

   // ------------------------------------------------------------
   // Flag status words
   // ------------------------------------------------------------
   logic [mqrps_pkg::STAT_W-1:0] sidx_reg, sidx_next, poll_reg, poll_next;
   logic [mqrps_pkg::STAT_W-1:0] idx;
   logic [mqrps_pkg::DEV_W-1:0] sdev_reg, sdev_next;
   logic [mqrps_pkg::FLAG_W-1:0] ae_reg, ae_next, pr_reg, pr_next;
   logic st_fire, st_show;

   always_comb begin
      st_fire = flag_status_strobe_i & !mrs_active;
      sidx_next = sidx_reg;
      sdev_next = sdev_reg;
      if (st_fire) begin
         sidx_next = a[mqrps_pkg::STAT_LSB +: mqrps_pkg::STAT_W];
         sdev_next = a[mqrps_pkg::DEV_LSB +: mqrps_pkg::DEV_W];
      end
      poll_next = flag_polled_mode_i ? poll_reg + 4'h1 : '0;
      idx = flag_polled_mode_i ? poll_reg : sidx_reg;
      st_show = flag_polled_mode_i | dev_hit(sdev_reg, id_reg);
      ae_next = st_show ? pick_word(ae_words_i, idx) : mqrps_pkg::FLAG_IDLE;
      pr_next = st_show ? pick_word(pr_words_i, idx) : mqrps_pkg::FLAG_IDLE;
   end
   assign almost_empty_status_bus_o = ae_reg;
   assign packet_ready_status_bus_o = pr_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sidx_reg <= '0;
         poll_reg <= '0;
         sdev_reg <= mqrps_pkg::DEV_ID_RST;
         ae_reg <= mqrps_pkg::FLAG_IDLE;
         pr_reg <= mqrps_pkg::FLAG_IDLE;
      end else begin
         sidx_reg <= sidx_next;
         poll_reg <= poll_next;
         sdev_reg <= sdev_next;
         ae_reg <= ae_next;
         pr_reg <= pr_next;
      end
   end

   // ------------------------------------------------------------
   // Serial configuration load
   // ------------------------------------------------------------
   mqrps_pkg::mqrps_ser_t ser_reg, ser_next;
   logic [mqrps_pkg::CFG_W-1:0] cfg_reg, cfg_next;
   logic [mqrps_pkg::CFG_CNT_W-1:0] cnt_reg, cnt_next;
   logic sclk_d_reg, prog_reg, prog_next, serial_out_enable_n_reg, serial_out_enable_n_next, shift;

   always_comb begin
      ser_next = ser_reg;
      cfg_next = cfg_reg;
      cnt_next = cnt_reg;
      prog_next = mrs_active ? prog_s : prog_reg;
      shift = 1'b0;
      case (ser_reg)
         mqrps_pkg::SER_IDLE: begin
            if (!mrs_active) begin
               ser_next = prog_reg ? mqrps_pkg::SER_SHIFT
                                   : mqrps_pkg::SER_DONE;
            end
         end
         mqrps_pkg::SER_SHIFT: begin
            shift = sclk_s & !sclk_d_reg & !serial_in_enable_n_s;
            if (shift) begin
               cfg_next = {cfg_reg[mqrps_pkg::CFG_W-2:0], si_s};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == mqrps_pkg::CFG_LAST) begin
                  ser_next = mqrps_pkg::SER_DONE;
               end
            end
         end
         mqrps_pkg::SER_DONE: begin
            ser_next = mqrps_pkg::SER_DONE;
         end
         default: begin
            ser_next = mqrps_pkg::SER_IDLE;
         end
      endcase
      if (mrs_active) begin
         ser_next = mqrps_pkg::SER_IDLE;
         cnt_next = '0;
      end
      serial_out_enable_n_next = (ser_next == mqrps_pkg::SER_DONE) ? serial_in_enable_n_s : 1'b1;
   end
   assign ser_done = (ser_reg == mqrps_pkg::SER_DONE) & !serial_out_enable_n_reg;
   assign serial_out_enable_n_o = serial_out_enable_n_reg;
   assign cfg_word_o = cfg_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ser_reg <= mqrps_pkg::SER_IDLE;
         cfg_reg <= '0;
         cnt_reg <= '0;
         sclk_d_reg <= 1'b0;
         prog_reg <= 1'b0;
         serial_out_enable_n_reg <= 1'b1;
      end else begin
         ser_reg <= ser_next;
         cfg_reg <= cfg_next;
         cnt_reg <= cnt_next;
         sclk_d_reg <= sclk_s;
         prog_reg <= prog_next;
         serial_out_enable_n_reg <= serial_out_enable_n_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_oe_needs_enable: assert property (
      read_data_oe_o |-> !read_chip_select_n_i && !read_en_n_i)
      else $error("output enabled without select and enable");
   a_oe_off_reset: assert property (
      mrs_active |-> !read_data_oe_o)
      else $error("output enabled during master reset");
   a_queue_capture: assert property (
      sel_fire |=> queue_reg == $past(a[4:0]) && rdev_reg == $past(a[7:5]))
      else $error("queue address not captured");
   a_queue_hold: assert property (
      !sel_fire && !mrs_active |=> $stable(queue_reg))
      else $error("queue changed without address enable");
   a_fall_through: assert property (
      (sel_fire && fall_through_mode_i) ##1 (fifo_ov && selected)
      |=> q_valid_reg)
      else $error("new queue word not shown two edges on");
   a_status_capture: assert property (
      st_fire |=> sidx_reg == $past(a[3:0]))
      else $error("status word address not captured");
   a_direct_word: assert property (
      st_fire && !flag_polled_mode_i ##1 !flag_polled_mode_i
      && dev_hit(sdev_reg, id_reg) |=> ae_reg == $past(pick_word(
      ae_words_i, sidx_reg)))
      else $error("wrong status word shown");
   a_poll_runs: assert property (
      flag_polled_mode_i |=> poll_reg == $past(poll_reg) + 4'h1)
      else $error("poll index stalled");
   a_read_needs_en: assert property (
      load && !fall_through_mode_i |-> !read_en_n_i)
      else $error("read without read enable");
   a_serial_gate: assert property (
      cnt_reg != $past(cnt_reg) && !$past(mrs_active) |-> $past(prog_reg))
      else $error("serial shift without serial programming");

   c_queue_switch: cover property (sel_fire ##2 q_valid_reg);
   c_status_pick: cover property (st_fire ##1 dev_hit(sdev_reg, id_reg));
   c_serial_done: cover property (prog_reg ##1 ser_done);
   c_fifo_full: cover property (!mem_ready_o);
endmodule

// ===== verification/mqrps_ctrl_model.sv
// Read controller model that drives queue and status selects
module mqrps_ctrl_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Requests from the bench, and serial output enable from the top
   input wire logic req_sel_i,
   input wire logic req_stb_i,
   input wire logic [7:0] req_addr_i,
   input wire logic serial_out_enable_n_i,
   // Read controller pins
   output logic read_addr_enable_o,
   output logic flag_status_strobe_o,
   output logic [7:0] read_queue_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // One-cycle select or strobe; address toggles when not in use
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         read_addr_enable_o <= 1'b0;
         flag_status_strobe_o <= 1'b0;
         read_queue_addr_o <= 8'h00;
      end else begin
         read_addr_enable_o <= req_sel_i && !serial_out_enable_n_i;
         flag_status_strobe_o <= req_stb_i && !req_sel_i;
         if (req_sel_i || req_stb_i) begin
            read_queue_addr_o <= req_addr_i;
         end else begin
            read_queue_addr_o <= ~read_queue_addr_o;
         end
      end
   end
endmodule

// ===== verification/multiqueue_read_port_select_test.sv
// Self-checking bench for the read port select block
module multiqueue_read_port_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i, rstn_i, master_reset_n_i, serial_clk_i, serial_data_i;
   logic serial_in_enable_n_i, serial_prog_sel_i, read_chip_select_n_i;
   logic read_en_n_i, fall_through_mode_i, flag_polled_mode_i, mem_valid_i;
   logic read_addr_enable_i, flag_status_strobe_i, read_data_oe_o;
   logic mem_ready_o, serial_out_enable_n_o, req_sel, req_stb, b4;
   logic [2:0] device_id_i, dev, odev;
   logic [7:0] read_queue_addr_i, req_addr;
   logic [7:0] almost_empty_status_bus_o, packet_ready_status_bus_o;
   logic [35:0] read_data_o, mem_data_i, w;
   logic [4:0] mem_queue_o, q;
   logic [3:0] idx;
   logic [127:0] ae_words_i, pr_words_i;
   logic [15:0] cfg_word_o, cfg;
   logic [25:0] mem_cnt = 26'h0;
   integer seed, err_count, samples_checked, i, n;

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Queue memory: tag of queue in top bits, push count below
   assign mem_data_i = {mem_queue_o, ~mem_queue_o, mem_cnt};
   always @(posedge clk_i) begin
      if (mem_valid_i && mem_ready_o) begin
         mem_cnt <= mem_cnt + 26'h1;
      end
   end

   mqrps_ctrl_model mqrps_ctrl_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .req_sel_i(req_sel), .req_stb_i(req_stb), .req_addr_i(req_addr),
      .serial_out_enable_n_i(serial_out_enable_n_o),
      .read_addr_enable_o(read_addr_enable_i),
      .flag_status_strobe_o(flag_status_strobe_i),
      .read_queue_addr_o(read_queue_addr_i));

   mqrps_top mqrps_top_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .master_reset_n_i(master_reset_n_i), .serial_clk_i(serial_clk_i),
      .serial_data_i(serial_data_i),
      .serial_in_enable_n_i(serial_in_enable_n_i),
      .serial_prog_sel_i(serial_prog_sel_i), .device_id_i(device_id_i),
      .read_chip_select_n_i(read_chip_select_n_i),
      .read_en_n_i(read_en_n_i), .read_addr_enable_i(read_addr_enable_i),
      .flag_status_strobe_i(flag_status_strobe_i),
      .read_queue_addr_i(read_queue_addr_i),
      .fall_through_mode_i(fall_through_mode_i),
      .flag_polled_mode_i(flag_polled_mode_i), .read_data_o(read_data_o),
      .read_data_oe_o(read_data_oe_o), .mem_queue_o(mem_queue_o),
      .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i),
      .mem_ready_o(mem_ready_o), .ae_words_i(ae_words_i),
      .pr_words_i(pr_words_i),
      .almost_empty_status_bus_o(almost_empty_status_bus_o),
      .packet_ready_status_bus_o(packet_ready_status_bus_o),
      .serial_out_enable_n_o(serial_out_enable_n_o), .cfg_word_o(cfg_word_o));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [35:0] tag_of(input logic [4:0] qq);
      return {qq, ~qq, 26'h0};
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   task automatic do_req(input logic sel, input logic [7:0] a);
      @(posedge clk_i);
      req_sel <= sel;
      req_stb <= !sel;
      req_addr <= a;
      @(posedge clk_i);
      req_sel <= 1'b0;
      req_stb <= 1'b0;
      cyc(3);
      #1;
   endtask

   task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h51fc40a7;
      err_count = 0;
      samples_checked = 0;
      dev = 3'($random(seed));
      odev = dev ^ 3'h5;
      rstn_i = 1'b0;
      master_reset_n_i = 1'b0;
      serial_clk_i = 1'b0;
      serial_data_i = 1'b0;
      serial_in_enable_n_i = 1'b1;
      serial_prog_sel_i = 1'b1;
      device_id_i = dev;
      read_chip_select_n_i = 1'b0;
      read_en_n_i = 1'b0;
      fall_through_mode_i = 1'b1;
      flag_polled_mode_i = 1'b0;
      mem_valid_i = 1'b1;
      ae_words_i = {$random(seed), $random(seed), $random(seed), $random(seed)};
      pr_words_i = {$random(seed), $random(seed), $random(seed), $random(seed)};
      req_sel = 1'b0;
      req_stb = 1'b0;
      req_addr = 8'h00;
      cyc(16);
      rstn_i <= 1'b1;
      cyc(4);
      #1;
      chk_bit(read_data_oe_o, 1'b0);
      chk_flag(almost_empty_status_bus_o, mqrps_pkg::FLAG_IDLE);
      chk_bit(serial_out_enable_n_o, 1'b1);
      @(posedge clk_i);
      master_reset_n_i <= 1'b1;
      serial_in_enable_n_i <= 1'b0;
      cyc(6);
      // Serial load, first bit ends up on top
      cfg = 16'($random(seed));
      for (i = 15; i >= 0; i--) begin
         serial_data_i <= cfg[i];
         cyc(4);
         serial_clk_i <= 1'b1;
         cyc(4);
         serial_clk_i <= 1'b0;
      end
      cyc(8);
      #1;
      chk_data({20'h0, cfg_word_o}, {20'h0, cfg});
      n = 0;
      while (serial_out_enable_n_o !== 1'b0 && n < 100) begin
         cyc(1);
         #1;
         n++;
      end
      if (n == 100) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
         test_done();
      end
      // Fall-through selects with read enable off, corner queues first
      @(posedge clk_i);
      read_en_n_i <= 1'b1;
      for (i = 0; i < 6; i++) begin
         q = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($random(seed));
         do_req(1'b1, {dev, q});
         chk_data({read_data_o[35:26], 26'h0}, tag_of(q));
         w = read_data_o;
         cyc(5);
         #1;
         chk_data(read_data_o, w);
         @(posedge clk_i);
         read_en_n_i <= 1'b0;
         @(posedge clk_i);
         read_en_n_i <= 1'b1;
         cyc(1);
         #1;
         chk_bit(read_data_o !== w, 1'b1);
         chk_data({read_data_o[35:26], 26'h0}, tag_of(q));
      end
      // Output enable against chip select and read enable
      for (i = 0; i < 4; i++) begin
         @(posedge clk_i);
         read_chip_select_n_i <= i[0];
         read_en_n_i <= i[1];
         cyc(1);
         #1;
         chk_bit(read_data_oe_o, !i[0] && !i[1]);
      end
      // Select aimed at another device leaves data alone
      w = read_data_o;
      do_req(1'b1, {odev, 5'($random(seed))});
      chk_data(read_data_o, w);
      // Direct status word select, bit four random
      for (i = 0; i < 5; i++) begin
         idx = (i == 0) ? 4'hf : 4'($random(seed));
         b4 = (i == 0) ? 1'b1 : 1'($random(seed));
         do_req(1'b0, {dev, b4, idx});
         chk_flag(almost_empty_status_bus_o,
            ae_words_i[int'(idx)*8 +: 8]);
         chk_flag(packet_ready_status_bus_o,
            pr_words_i[int'(idx)*8 +: 8]);
      end
      do_req(1'b0, {odev, 1'b0, idx});
      chk_flag(almost_empty_status_bus_o, mqrps_pkg::FLAG_IDLE);
      // Polled status words cycle from word zero, read enable off
      @(posedge clk_i);
      flag_polled_mode_i <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_i);
         #1;
         chk_flag(almost_empty_status_bus_o, ae_words_i[i*8 +: 8]);
      end
      @(posedge clk_i);
      flag_polled_mode_i <= 1'b0;
      // Master reset mid-run with chip selected
      @(posedge clk_i);
      read_chip_select_n_i <= 1'b0;
      read_en_n_i <= 1'b0;
      master_reset_n_i <= 1'b0;
      cyc(4);
      #1;
      chk_bit(read_data_oe_o, 1'b0);
      test_done();
   end
endmodule
